// >>> shared/tws_pkg.sv
// Constants, register map and state codes of the two-wire serial block
package tws_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_BUS_DATA  = 8'h9a;
   localparam logic [ADDR_W-1:0] OFS_OWN_ADDR  = 8'h9b;
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'he8;
   localparam logic [ADDR_W-1:0] OFS_CFG       = 8'he9;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'hea;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'heb;

   // two_wire_control bit positions
   localparam int unsigned CB_SW_MASTER_SDA_OUT     = 7;
   localparam int unsigned CB_SW_MASTER_SDA_DRIVE_EN = 6;
   localparam int unsigned CB_SW_MASTER_SCL_OUT     = 5;
   localparam int unsigned CB_SW_MASTER_SDA_IN      = 4;
   localparam int unsigned CB_MASTER_SELECT         = 3;
   localparam int unsigned CB_INTERFACE_RESET_BIT   = 2;
   localparam int unsigned CB_SLAVE_DIRECTION_FLAG  = 1;
   localparam int unsigned CB_BYTE_DONE_FLAG        = 0;

   // Configuration register bit
   localparam int unsigned CFG_SPI_SELECT_BIT = 0;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_W          = 3;
   localparam int unsigned IRQ_BYTE_DONE  = 0;
   localparam int unsigned IRQ_ADDR_MATCH = 1;
   localparam int unsigned IRQ_STOP       = 2;

   // Reset values
   localparam logic [DATA_W-1:0] RST_BUS_DATA = 8'h00;
   localparam logic [DATA_W-1:0] RST_OWN_ADDR = 8'h55;
   localparam logic [IRQ_W-1:0]  RST_IRQ_MASK = 3'h0;

   // Bit counting within a byte
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ACK_ADDR = 3'b010,
      ST_RX       = 3'b011,
      ST_ACK_RX   = 3'b100,
      ST_TX       = 3'b101,
      ST_TX_ACK   = 3'b110
   } tws_state_e;

endpackage

// >>> shared/tws_line_if.sv
// Synchronised bus line levels and events passed to the protocol logic
`timescale 1ns/10ps
interface tws_line_if;
   logic sda;
   logic scl;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;

   modport src (output sda, scl, scl_rise, scl_fall, start, stop);
   modport snk (input  sda, scl, scl_rise, scl_fall, start, stop);
endinterface

// >>> logic/tws_pin_sync.sv
// Two-flop pin synchroniser with clock-edge and start/stop detection
`timescale 1ns/10ps
module tws_pin_sync
   import tws_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic sda_i,
   input  wire logic scl_i,
   tws_line_if.src   line
);

   typedef struct packed {
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic scl_m;
      logic scl_s;
      logic scl_p;
   } tws_sync_s;

   tws_sync_s s_r;
   tws_sync_s s_nxt;

   always_comb begin
      s_nxt       = s_r;
      s_nxt.sda_m = sda_i;
      s_nxt.sda_s = s_r.sda_m;
      s_nxt.sda_p = s_r.sda_s;
      s_nxt.scl_m = scl_i;
      s_nxt.scl_s = s_r.scl_m;
      s_nxt.scl_p = s_r.scl_s;
   end

   // Bus idles high, so reset to the released level
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign line.sda      = s_r.sda_s;
   assign line.scl      = s_r.scl_s;
   assign line.scl_rise = s_r.scl_s & ~s_r.scl_p;
   assign line.scl_fall = ~s_r.scl_s & s_r.scl_p;
   // Data moving while the clock stays high marks start or stop
   assign line.start    = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
   assign line.stop     = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;

endmodule

// >>> logic/tws_top.sv
// Two-wire serial block: software master pins and hardware slave engine
//
// Behaviour
// R1: Master drives data bit when enabled
// R2: Drive enable selects data pin direction
// R3: Master clock bit drives clock pin
// R4: Data pin latched on clock when receiving
// R5: Master select picks master or slave
// R6: Interface reset bit holds slave engine
// R7: Direction flag shows slave transmitting
// R8: Byte-done flag set per byte, software clears
// R9: Own address writable, resets to 55H
// R10: Data register sends written, returns received
// R11: Software touches data once per byte
// R12: Pins shared with SPI, select bit
// R13: Slave answers only its own address
// R14: Start, stop, acknowledge, MSB first
`timescale 1ns/10ps
module tws_top
   import tws_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output      logic [DATA_W-1:0] rdata,
   output      logic              irq,
   input  wire logic              sda_i,
   output      logic              sda_o,
   output      logic              sda_oe,
   input  wire logic              scl_i,
   output      logic              scl_o,
   output      logic              scl_oe
);

   typedef struct packed {
      logic [DATA_W-1:0] bus_data;
      logic [DATA_W-1:0] own_addr;
      logic              sda_out;
      logic              sda_drive_en;
      logic              scl_out;
      logic              sda_in;
      logic              master_select;
      logic              iface_reset;
      logic              direction;
      logic              byte_done;
      logic              spi_select;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      tws_state_e        state;
      logic [3:0]        bit_cnt;
      logic [DATA_W-1:0] shift;
      logic              ack_ok;
      logic              slv_sda_low;
      logic [DATA_W-1:0] rdata;
      logic              irq;
      logic              sda_o;
      logic              sda_oe;
      logic              scl_o;
      logic              scl_oe;
   } tws_top_s;

   tws_top_s s_r;
   tws_top_s s_nxt;

   logic             slave_on;
   logic [IRQ_W-1:0] ev;

   tws_line_if line ();

   tws_pin_sync u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .sda_i  (sda_i),
      .scl_i  (scl_i),
      .line   (line.src)
   );

   function automatic logic [DATA_W-1:0] ctrl_pack(input tws_top_s s);
      logic [DATA_W-1:0] v;
      v                            = 8'h00;
      v[CB_SW_MASTER_SDA_OUT]      = s.sda_out;
      v[CB_SW_MASTER_SDA_DRIVE_EN] = s.sda_drive_en;
      v[CB_SW_MASTER_SCL_OUT]      = s.scl_out;
      v[CB_SW_MASTER_SDA_IN]       = s.sda_in;
      v[CB_MASTER_SELECT]          = s.master_select;
      v[CB_INTERFACE_RESET_BIT]    = s.iface_reset;
      v[CB_SLAVE_DIRECTION_FLAG]   = s.direction;
      v[CB_BYTE_DONE_FLAG]         = s.byte_done;
      return v;
   endfunction

   function automatic logic [DATA_W-1:0] read_mux(input tws_top_s s,
                                                  input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      v = 8'h00;
      case (a)
         OFS_BUS_DATA: begin
            v = s.bus_data;
         end
         OFS_OWN_ADDR: begin
            v = s.own_addr;
         end
         OFS_CTRL: begin
            v = ctrl_pack(s);
         end
         OFS_CFG: begin
            v[CFG_SPI_SELECT_BIT] = s.spi_select;
         end
         OFS_IRQ_STAT: begin
            v[IRQ_W-1:0] = s.irq_stat;
         end
         OFS_IRQ_MASK: begin
            v[IRQ_W-1:0] = s.irq_mask;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   always_comb begin
      s_nxt       = s_r;
      s_nxt.rdata = 8'h00;
      ev          = '0;
      // R5: mode select
      // R6: engine held in reset
      // R12: SPI owns pins
      slave_on    = !s_r.spi_select && !s_r.master_select && !s_r.iface_reset;

      if (wr_en) begin
         case (addr)
            OFS_BUS_DATA: begin
               // R10: byte to transmit
               s_nxt.bus_data = wdata;
            end
            OFS_OWN_ADDR: begin
               // R9: address writable
               s_nxt.own_addr = wdata;
            end
            OFS_CTRL: begin
               s_nxt.sda_out       = wdata[CB_SW_MASTER_SDA_OUT];
               s_nxt.sda_drive_en  = wdata[CB_SW_MASTER_SDA_DRIVE_EN];
               s_nxt.scl_out       = wdata[CB_SW_MASTER_SCL_OUT];
               s_nxt.master_select = wdata[CB_MASTER_SELECT];
               s_nxt.iface_reset   = wdata[CB_INTERFACE_RESET_BIT];
               // R8: software clears by writing zero
               if (!wdata[CB_BYTE_DONE_FLAG]) begin
                  s_nxt.byte_done = 1'b0;
               end
            end
            OFS_CFG: begin
               s_nxt.spi_select = wdata[CFG_SPI_SELECT_BIT];
            end
            OFS_IRQ_STAT: begin
               s_nxt.irq_stat = s_r.irq_stat & ~wdata[IRQ_W-1:0];
            end
            OFS_IRQ_MASK: begin
               s_nxt.irq_mask = wdata[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      if (rd_en) begin
         // R10: received byte readback
         s_nxt.rdata = read_mux(s_r, addr);
      end

      // R4: sample data pin on clock rise
      if (s_r.master_select && !s_r.sda_drive_en && line.scl_rise) begin
         s_nxt.sda_in = line.sda;
      end

      if (!slave_on) begin
         // R6: engine idle and bus released
         s_nxt.state       = ST_IDLE;
         s_nxt.bit_cnt     = 4'h0;
         s_nxt.slv_sda_low = 1'b0;
      end else if (line.stop) begin
         // R14: stop ends any transfer
         if (s_r.state != ST_IDLE) begin
            ev[IRQ_STOP] = 1'b1;
         end
         s_nxt.state       = ST_IDLE;
         s_nxt.slv_sda_low = 1'b0;
      end else if (line.start) begin
         // R14: start, repeated or not, restarts address phase
         s_nxt.state       = ST_ADDR;
         s_nxt.bit_cnt     = 4'h0;
         s_nxt.slv_sda_low = 1'b0;
      end else begin
         case (s_r.state)
            ST_IDLE: begin
               s_nxt.slv_sda_low = 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (line.scl_rise && s_r.bit_cnt != BYTE_BITS) begin
                  // R14: MSB first shift in
                  s_nxt.shift   = {s_r.shift[DATA_W-2:0], line.sda};
                  s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               end else if (line.scl_fall && s_r.bit_cnt == BYTE_BITS) begin
                  s_nxt.bit_cnt = 4'h0;
                  if (s_r.state == ST_ADDR) begin
                     // R13: own address compare
                     if (s_r.shift[7:1] == s_r.own_addr[6:0]) begin
                        ev[IRQ_ADDR_MATCH] = 1'b1;
                        s_nxt.slv_sda_low  = 1'b1;
                        // R7: direction from read/write bit
                        s_nxt.direction    = s_r.shift[0];
                        s_nxt.state        = ST_ACK_ADDR;
                     end else begin
                        s_nxt.state = ST_IDLE;
                     end
                  end else begin
                     // R8: byte received
                     ev[IRQ_BYTE_DONE]  = 1'b1;
                     s_nxt.bus_data     = s_r.shift;
                     s_nxt.slv_sda_low  = 1'b1;
                     s_nxt.state        = ST_ACK_RX;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (line.scl_fall) begin
                  s_nxt.bit_cnt = 4'h0;
                  if (s_r.direction) begin
                     // R14: first bit out MSB first
                     s_nxt.shift       = s_r.bus_data;
                     s_nxt.slv_sda_low = ~s_r.bus_data[DATA_W-1];
                     s_nxt.state       = ST_TX;
                  end else begin
                     s_nxt.slv_sda_low = 1'b0;
                     s_nxt.state       = ST_RX;
                  end
               end
            end
            ST_ACK_RX: begin
               if (line.scl_fall) begin
                  s_nxt.slv_sda_low = 1'b0;
                  s_nxt.state       = ST_RX;
               end
            end
            ST_TX: begin
               if (line.scl_fall) begin
                  if (s_r.bit_cnt == LAST_TX_BIT) begin
                     // R8: byte transmitted
                     ev[IRQ_BYTE_DONE] = 1'b1;
                     s_nxt.slv_sda_low = 1'b0;
                     s_nxt.bit_cnt     = 4'h0;
                     s_nxt.state       = ST_TX_ACK;
                  end else begin
                     s_nxt.shift       = {s_r.shift[DATA_W-2:0], 1'b0};
                     s_nxt.slv_sda_low = ~s_r.shift[DATA_W-2];
                     s_nxt.bit_cnt     = s_r.bit_cnt + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (line.scl_rise) begin
                  s_nxt.ack_ok = ~line.sda;
               end else if (line.scl_fall) begin
                  if (s_r.ack_ok) begin
                     // Next byte taken from data register as it stands now
                     s_nxt.shift       = s_r.bus_data;
                     s_nxt.slv_sda_low = ~s_r.bus_data[DATA_W-1];
                     s_nxt.state       = ST_TX;
                  end else begin
                     // Master refused; wait for stop
                     s_nxt.state = ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.state       = ST_IDLE;
               s_nxt.slv_sda_low = 1'b0;
            end
         endcase
      end

      // Hardware set wins over a same-cycle software clear
      if (ev[IRQ_BYTE_DONE]) begin
         s_nxt.byte_done = 1'b1;
      end
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);

      // Pin drivers, registered so the pads never see decode glitches
      if (s_nxt.spi_select) begin
         // R12: two-wire pins released
         s_nxt.sda_o  = 1'b0;
         s_nxt.sda_oe = 1'b0;
         s_nxt.scl_o  = 1'b0;
         s_nxt.scl_oe = 1'b0;
      end else if (s_nxt.master_select) begin
         // R1: data bit when enabled
         // R2: enable sets direction
         s_nxt.sda_o  = s_nxt.sda_out;
         s_nxt.sda_oe = s_nxt.sda_drive_en;
         // R3: clock bit straight out
         s_nxt.scl_o  = s_nxt.scl_out;
         s_nxt.scl_oe = 1'b1;
      end else begin
         // Slave pulls data low only; no clock stretching
         s_nxt.sda_o  = 1'b0;
         s_nxt.sda_oe = s_nxt.slv_sda_low;
         s_nxt.scl_o  = 1'b0;
         s_nxt.scl_oe = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_r          <= '0;
         s_r.state    <= ST_IDLE;
         s_r.bus_data <= RST_BUS_DATA;
         // R9: power-on address
         s_r.own_addr <= RST_OWN_ADDR;
         s_r.irq_mask <= RST_IRQ_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata  = s_r.rdata;
   assign irq    = s_r.irq;
   assign sda_o  = s_r.sda_o;
   assign sda_oe = s_r.sda_oe;
   assign scl_o  = s_r.scl_o;
   assign scl_oe = s_r.scl_oe;

endmodule

// >>> dv/tws_top_properties.sv
// Port-level checker for the two-wire block, bound to its top module
`timescale 1ns/10ps
module tws_top_chk
   import tws_pkg::*;
(
   input wire logic              clock,
   input wire logic              arst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr_en,
   input wire logic              rd_en,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              irq,
   input wire logic              sda_i,
   input wire logic              sda_o,
   input wire logic              sda_oe,
   input wire logic              scl_i,
   input wire logic              scl_o,
   input wire logic              scl_oe
);
   // Shadow of control plus spi select; pins judged only once settled
   logic [8:0] cf_r;
   logic [8:0] d1_r;
   logic [8:0] d2_r;
   logic [7:0] own_r;
   logic [7:0] msk_r;
   logic       stab;
   logic       m_act;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cf_r  <= 9'h000;
         d1_r  <= 9'h000;
         d2_r  <= 9'h000;
         own_r <= RST_OWN_ADDR;
         msk_r <= 8'h00;
      end else begin
         if (wr_en && addr == OFS_CTRL) cf_r[7:0] <= wdata;
         if (wr_en && addr == OFS_CFG) cf_r[8] <= wdata[0];
         if (wr_en && addr == OFS_OWN_ADDR) own_r <= wdata;
         if (wr_en && addr == OFS_IRQ_MASK) msk_r <= {5'h00, wdata[2:0]};
         d1_r <= cf_r;
         d2_r <= d1_r;
      end
   end
   assign stab  = (cf_r == d1_r) && (cf_r == d2_r);
   assign m_act = stab && cf_r[3] && !cf_r[8];

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_sda_drive; m_act && cf_r[6] |-> sda_oe && sda_o == cf_r[7]; endproperty
   a_sda_drive: assert property (p_sda_drive) else $error("data pin not driven");
   property p_sda_input; m_act && !cf_r[6] |-> !sda_oe; endproperty
   a_sda_input: assert property (p_sda_input) else $error("data pin not released");
   property p_scl_drive; m_act |-> scl_oe && scl_o == cf_r[5]; endproperty
   a_scl_drive: assert property (p_scl_drive) else $error("clock pin mismatch");
   property p_slave_mode; stab && !cf_r[3] |-> !scl_oe && !sda_o; endproperty
   a_slave_mode: assert property (p_slave_mode) else $error("slave drives wrongly");
   property p_if_reset; stab && !cf_r[3] && cf_r[2] |-> !sda_oe; endproperty
   a_if_reset: assert property (p_if_reset) else $error("engine active in reset");
   property p_spi_sel; stab && cf_r[8] |-> !sda_oe && !scl_oe; endproperty
   a_spi_sel: assert property (p_spi_sel) else $error("pins driven under spi");
   property p_irq_mask; msk_r == 8'h00 && $past(msk_r) == 8'h00 |-> !irq; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
   property p_own_read; rd_en && addr == OFS_OWN_ADDR |=> rdata == own_r; endproperty
   a_own_read: assert property (p_own_read) else $error("own address readback");
   property p_rdata_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule

bind tws_top tws_top_chk u_chk (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe));

// >>> dv/tws_bus_master.sv
// Behavioural far-side bus master, open drain on both lines
`timescale 1ns/10ps
module tws_bus_master #(
   parameter int HALF = 20
) (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   initial {scl_low, sda_low} = 2'b00;

   task automatic hp();
      repeat (HALF) @(posedge clock);
   endtask

   task automatic start();
      sda_low <= 1'b1;
      hp();
      scl_low <= 1'b1;
      hp();
   endtask

   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      hp();
      scl_low <= 1'b0;
      hp();
      r = sda;
      scl_low <= 1'b1;
      hp();
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask

   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, a);
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      hp();
      scl_low <= 1'b0;
      hp();
      sda_low <= 1'b0;
      hp();
   endtask
endmodule

// >>> dv/tws_top_tb.sv
// Self-checking bench for the two-wire block
`timescale 1ns/10ps
module tws_top_tb
   import tws_pkg::*;
();
   logic              clock   = 1'b0;
   logic              arst_n  = 1'b0;
   logic [ADDR_W-1:0] addr    = 8'h00;
   logic [DATA_W-1:0] wdata   = 8'h00;
   logic              wr_en   = 1'b0;
   logic              rd_en   = 1'b0;
   logic              ext_low = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              irq;
   logic              sda_o;
   logic              sda_oe;
   logic              scl_o;
   logic              scl_oe;
   logic              m_scl_low;
   logic              m_sda_low;
   int                err_count = 0;
   int                compares  = 0;
   // Pull-ups on both lines
   wire               sda = !((sda_oe && !sda_o) || m_sda_low || ext_low);
   wire               scl = scl_oe ? scl_o : !m_scl_low;

   always #20 clock = ~clock;

   tws_top DUT (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .irq(irq), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe));
   tws_bus_master u_far (.clock(clock), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));

   task automatic stop_test();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string what);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(posedge clock);
      chk(rdata & m, e, what);
   endtask

   function automatic logic [7:0] pins();
      return {4'h0, sda_oe, sda_oe & sda_o, scl_oe, scl_oe & scl_o};
   endfunction

   task automatic t_regs();
      rdc(OFS_BUS_DATA, 8'hff, 8'h00, "bus_data reset");
      rdc(OFS_OWN_ADDR, 8'hff, 8'h55, "own address reset");
      rdc(8'h10, 8'hff, 8'h00, "unmapped read");
      wr(OFS_OWN_ADDR, 8'h2a);
      rdc(OFS_OWN_ADDR, 8'hff, 8'h2a, "own address write");
   endtask

   task automatic t_master();
      logic [7:0] c [5] = '{8'he8, 8'h48, 8'h88, 8'h28, 8'h00};
      logic [7:0] p [5] = '{8'h0f, 8'h0a, 8'h02, 8'h03, 8'h00};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL, c[i]);
         repeat (3) @(posedge clock);
         chk(pins(), p[i], "master pins");
      end
      wr(OFS_CTRL, 8'he8);
      wr(OFS_CFG, 8'h01);
      repeat (3) @(posedge clock);
      chk(pins(), 8'h00, "spi owns pins");
      wr(OFS_CFG, 8'h00);
      for (int b = 0; b < 2; b++) begin
         ext_low <= (b == 0);
         wr(OFS_CTRL, 8'h08);
         wr(OFS_CTRL, 8'h28);
         repeat (4) @(posedge clock);
         rdc(OFS_CTRL, 8'h10, (b == 0) ? 8'h00 : 8'h10, "sda in latch");
      end
      ext_low <= 1'b0;
      wr(OFS_CTRL, 8'h00);
   endtask

   task automatic t_slv_write();
      logic ack;
      wr(OFS_IRQ_MASK, 8'h07);
      u_far.start();
      u_far.wbyte({7'h2a, 1'b0}, ack);
      chk({7'h00, ack}, 8'h00, "address ack");
      rdc(OFS_CTRL, 8'h02, 8'h00, "direction rx");
      u_far.wbyte(8'ha5, ack);
      chk({7'h00, ack}, 8'h00, "data ack");
      u_far.stop();
      repeat (8) @(posedge clock);
      rdc(OFS_BUS_DATA, 8'hff, 8'ha5, "received byte");
      rdc(OFS_CTRL, 8'h01, 8'h01, "byte done set");
      chk({7'h00, irq}, 8'h01, "irq raised");
      rdc(OFS_IRQ_STAT, 8'hff, 8'h07, "irq status");
      wr(OFS_IRQ_STAT, 8'h07);
      wr(OFS_CTRL, 8'h00);
      rdc(OFS_CTRL, 8'h01, 8'h00, "byte done cleared");
      chk({7'h00, irq}, 8'h00, "irq cleared");
   endtask

   task automatic t_slv_read();
      logic       ack;
      logic [7:0] d;
      wr(OFS_IRQ_MASK, 8'h00);
      wr(OFS_BUS_DATA, 8'hc3);
      u_far.start();
      u_far.wbyte({7'h2a, 1'b1}, ack);
      chk({7'h00, ack}, 8'h00, "read address ack");
      rdc(OFS_CTRL, 8'h02, 8'h02, "direction tx");
      // Shifter already holds the first byte, so this write feeds the second
      wr(OFS_BUS_DATA, 8'h3c);
      u_far.rbyte(1'b0, d);
      chk(d, 8'hc3, "sent byte");
      u_far.rbyte(1'b1, d);
      chk(d, 8'h3c, "second byte after ack");
      u_far.stop();
      repeat (8) @(posedge clock);
      rdc(OFS_CTRL, 8'h01, 8'h01, "byte done tx");
      chk({7'h00, irq}, 8'h00, "masked irq");
      rdc(OFS_IRQ_STAT, 8'h01, 8'h01, "status kept");
      wr(OFS_IRQ_STAT, 8'h07);
      wr(OFS_CTRL, 8'h00);
   endtask

   // Foreign address, then own address under interface reset
   task automatic t_refuse();
      logic ack;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CTRL, (i == 0) ? 8'h00 : 8'h04);
         u_far.start();
         u_far.wbyte((i == 0) ? 8'h22 : 8'h54, ack);
         chk({7'h00, ack}, 8'h01, "not acknowledged");
         u_far.stop();
      end
      wr(OFS_CTRL, 8'h00);
   endtask

   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_master();
      t_slv_write();
      t_slv_read();
      t_refuse();
      stop_test();
   end

   // Whole run needs about 4300 cycles
   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      stop_test();
   end
endmodule
